// *** core/cmsd_pkg.sv ***
// cmsd_pkg: constants and types shared by the memory space decoder and its ram.
// assumes an 8-bit data path and a 16-bit program address from the core.
package cmsd_pkg;

  // widths of the address spaces
  localparam int CMSD_DATA_AW = 8;
  localparam int CMSD_DATA_DEPTH = 256;
  localparam int CMSD_CODE_AW = 16;

  // program space: on-chip store and its reserved top
  localparam logic [15:0] CMSD_CODE_TOP = 16'h3FFF;
  localparam logic [15:0] CMSD_CODE_USABLE_TOP = 16'h3DFF;

  // data space split and bit-addressable region
  localparam logic [7:0] CMSD_LOWER_TOP = 8'h7F;
  localparam logic [3:0] CMSD_BIT_BYTE_HI = 4'h2;
  localparam logic [2:0] CMSD_BANK_SPACE = 3'h0;
  localparam logic [1:0] CMSD_PTR_SPACE = 2'h0;

  // special function registers kept in this block
  localparam logic [7:0] CMSD_STACK_TOP_POINTER_ADDR = 8'h81;
  localparam logic [7:0] CMSD_PROGRAM_STORE_CONTROL_ADDR = 8'h8F;
  localparam logic [7:0] CMSD_PROCESSOR_STATUS_WORD_ADDR = 8'hD0;

  // reset values
  localparam logic [7:0] CMSD_STACK_TOP_POINTER_RST = 8'h07;
  localparam logic [7:0] CMSD_PROGRAM_STORE_CONTROL_RST = 8'h00;
  localparam logic [7:0] CMSD_PROCESSOR_STATUS_WORD_RST = 8'h00;

  // field positions
  localparam int CMSD_STORE_WREN_BIT = 0;
  localparam int CMSD_BANK_SELECT_LOW_BIT = 3;
  localparam int CMSD_BANK_SELECT_HIGH_BIT = 4;

  // kinds of access the core can ask for
  typedef enum logic [2:0] {
    CMSD_K_DIRECT = 3'b000,
    CMSD_K_INDIRECT = 3'b001,
    CMSD_K_REGN = 3'b010,
    CMSD_K_BIT = 3'b011,
    CMSD_K_PUSH = 3'b100,
    CMSD_K_POP = 3'b101,
    CMSD_K_CODE = 3'b110,
    CMSD_K_XMOVE = 3'b111
  } cmsd_kind_t;

  // where an access lands
  typedef enum logic [2:0] {
    CMSD_T_NONE = 3'b000,
    CMSD_T_RAM = 3'b001,
    CMSD_T_SFRI = 3'b010,
    CMSD_T_SFRX = 3'b011,
    CMSD_T_PMEM = 3'b100,
    CMSD_T_XDATA = 3'b101
  } cmsd_tgt_t;

  // sequencer states
  typedef enum logic [1:0] {
    CMSD_S_IDLE = 2'b00,
    CMSD_S_PTR = 2'b01,
    CMSD_S_READ = 2'b10
  } cmsd_st_t;

endpackage

// *** core/cmsd_ram.sv ***
// cmsd_ram: single-port data ram with registered read data.
// assumes one clock; en_i/we_i come from logic on the same clock.
`timescale 1ns/1ps
module cmsd_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // access port
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];

  // storage array, no reset on the contents
  always_ff @(posedge clk_i) begin
    if (ce_i && en_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // read data register, holds old word on a write
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (ce_i && en_i && !we_i) begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule

// *** core/cmsd_decoder.sv ***
// cmsd_decoder: memory space decoder for the 8-bit core.
// assumes the core's execution logic on the same clock issues one access at a time,
// and that outside sfr, program store and external data answer in the strobe cycle.
//
// How it works
// - 64 KB program space; on-chip store spans 0x0000 to 0x3FFF.
// - program addresses above 0x3DFF are reserved and never reach the store.
// - store write enable bit turns external-move writes into program writes.
// - 256 bytes of data ram cover data addresses 0x00 to 0xFF.
// - lower 128 bytes reachable both directly and indirectly.
// - upper 128 ram bytes only indirectly; separate from sfr space.
// - indirect access above 0x7F always goes to upper ram.
// - direct access to 0x80..0xFF always goes to sfr space.
// - bytes 0x00..0x1F are four banks; status word bits 3,4 pick one.
// - indirect pointer is first or second register of active bank.
// - bytes 0x20..0x2F double as 128 bits, bit = 8*offset + position.
// - bit versus byte access chosen only by the access kind.
// - stack pointer sits at sfr 0x81, pointing at last used slot.
// - push stores at pointer plus one, then pointer increments.
// - reset loads stack pointer with 0x07.
// - stack lives anywhere in the 256 bytes; pointer wraps at 8 bits.
// - only sfrs with low nibble 0 or 8 are bit accessible.
// - program and data spaces overlap; access kind picks the space.
`timescale 1ns/1ps
module cmsd_decoder (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // request from the core
  input wire logic req_valid_i,
  input wire cmsd_pkg::cmsd_kind_t req_kind_i,
  input wire logic [15:0] req_addr_i,
  input wire logic req_write_i,
  input wire logic [7:0] req_wdata_i,
  input wire logic req_bit_i,
  // answer to the core
  output logic ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic rbit_o,
  output logic err_o,
  // registers kept here
  output logic [7:0] stack_top_pointer_o,
  output logic [7:0] program_store_control_o,
  output logic [7:0] processor_status_word_o,
  // outside sfr space
  output logic sfr_rd_o,
  output logic sfr_wr_o,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i,
  // program store
  output logic pmem_rd_o,
  output logic pmem_wr_o,
  output logic [15:0] pmem_addr_o,
  output logic [7:0] pmem_wdata_o,
  input wire logic [7:0] pmem_rdata_i,
  // external data space
  output logic xdata_rd_o,
  output logic xdata_wr_o,
  output logic [15:0] xdata_addr_o,
  output logic [7:0] xdata_wdata_o,
  input wire logic [7:0] xdata_rdata_i
);
  import cmsd_pkg::*;

  typedef struct packed {
    cmsd_st_t st;
    cmsd_tgt_t tgt;
    logic write;
    logic isbit;
    logic bitval;
    logic [2:0] bitpos;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ready;
    logic done;
    logic [7:0] rdata;
    logic rbit;
    logic err;
    logic [7:0] stack_top_pointer;
    logic [7:0] program_store_control;
    logic [7:0] processor_status_word;
    logic sfr_rd;
    logic sfr_wr;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic pmem_rd;
    logic pmem_wr;
    logic [15:0] pmem_addr;
    logic [7:0] pmem_wdata;
    logic xd_rd;
    logic xd_wr;
    logic [15:0] xd_addr;
    logic [7:0] xd_wdata;
  } cmsd_state_t;

  localparam cmsd_state_t CMSD_RST = '{
    st: CMSD_S_IDLE, tgt: CMSD_T_NONE, write: 1'b0, isbit: 1'b0, bitval: 1'b0,
    bitpos: 3'h0, addr: 8'h00, wdata: 8'h00, ready: 1'b1, done: 1'b0,
    rdata: 8'h00, rbit: 1'b0, err: 1'b0,
    stack_top_pointer: CMSD_STACK_TOP_POINTER_RST,
    program_store_control: CMSD_PROGRAM_STORE_CONTROL_RST,
    processor_status_word: CMSD_PROCESSOR_STATUS_WORD_RST,
    sfr_rd: 1'b0, sfr_wr: 1'b0, sfr_addr: 8'h00, sfr_wdata: 8'h00,
    pmem_rd: 1'b0, pmem_wr: 1'b0, pmem_addr: 16'h0000, pmem_wdata: 8'h00,
    xd_rd: 1'b0, xd_wr: 1'b0, xd_addr: 16'h0000, xd_wdata: 8'h00
  };

  cmsd_state_t st_r;
  cmsd_state_t st_nxt;

  // combinational ram port
  logic ram_en;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_q;

  // sfrs kept locally; every other sfr address goes outward
  function automatic logic is_local_sfr(input logic [7:0] a);
    return (a == CMSD_STACK_TOP_POINTER_ADDR) || (a == CMSD_PROGRAM_STORE_CONTROL_ADDR) ||
           (a == CMSD_PROCESSOR_STATUS_WORD_ADDR);
  endfunction

  // read mux of the local sfrs
  function automatic logic [7:0] local_sfr_rd(input logic [7:0] a, input cmsd_state_t s);
    return (a == CMSD_STACK_TOP_POINTER_ADDR) ? s.stack_top_pointer :
           (a == CMSD_PROGRAM_STORE_CONTROL_ADDR) ? s.program_store_control :
           (a == CMSD_PROCESSOR_STATUS_WORD_ADDR) ? s.processor_status_word : 8'h00;
  endfunction

  // address of a bank register n within the active bank
  function automatic logic [7:0] bank_addr(input logic [7:0] sw, input logic [2:0] n);
    return {CMSD_BANK_SPACE, sw[CMSD_BANK_SELECT_HIGH_BIT], sw[CMSD_BANK_SELECT_LOW_BIT], n};
  endfunction

  // byte value after a single-bit write
  function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] p,
                                         input logic v);
    logic [7:0] r;
    r = b;
    r[p] = v;
    return r;
  endfunction

  cmsd_ram #(
    .AW(CMSD_DATA_AW),
    .DW(8)
  ) u_ram (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .en_i(ram_en),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_q)
  );

  // next-state logic of the whole decoder
  always_comb begin
    logic [7:0] data;
    logic [7:0] a8;
    logic [7:0] newb;
    data = 8'h00;
    a8 = req_addr_i[7:0];
    newb = 8'h00;
    st_nxt = st_r;
    ram_en = 1'b0;
    ram_we = 1'b0;
    ram_addr = 8'h00;
    ram_wdata = 8'h00;
    // strobes last one cycle
    st_nxt.done = 1'b0;
    st_nxt.sfr_rd = 1'b0;
    st_nxt.sfr_wr = 1'b0;
    st_nxt.pmem_rd = 1'b0;
    st_nxt.pmem_wr = 1'b0;
    st_nxt.xd_rd = 1'b0;
    st_nxt.xd_wr = 1'b0;
    unique case (st_r.st)
      CMSD_S_IDLE: begin
        if (req_valid_i && st_r.ready) begin
          st_nxt.write = req_write_i;
          st_nxt.wdata = req_wdata_i;
          st_nxt.bitval = req_bit_i;
          st_nxt.isbit = 1'b0;
          st_nxt.bitpos = a8[2:0];
          st_nxt.err = 1'b0;
          st_nxt.tgt = CMSD_T_NONE;
          st_nxt.st = CMSD_S_READ;
          unique case (req_kind_i)
            CMSD_K_DIRECT, CMSD_K_BIT: begin
              st_nxt.isbit = (req_kind_i == CMSD_K_BIT);
              if (req_kind_i == CMSD_K_BIT) begin
                st_nxt.addr = a8[7] ? {a8[7:3], 3'h0} : {CMSD_BIT_BYTE_HI, a8[6:3]};
              end else begin
                st_nxt.addr = a8;
              end
              if (st_nxt.addr > CMSD_LOWER_TOP) begin
                st_nxt.tgt = is_local_sfr(st_nxt.addr) ? CMSD_T_SFRI : CMSD_T_SFRX;
              end else begin
                st_nxt.tgt = CMSD_T_RAM;
              end
            end
            CMSD_K_REGN: begin
              st_nxt.addr = bank_addr(st_r.processor_status_word, a8[2:0]);
              st_nxt.tgt = CMSD_T_RAM;
            end
            CMSD_K_INDIRECT: begin
              st_nxt.addr = bank_addr(st_r.processor_status_word, {CMSD_PTR_SPACE, a8[0]});
              st_nxt.tgt = CMSD_T_RAM;
              st_nxt.st = CMSD_S_PTR;
            end
            CMSD_K_PUSH: begin
              st_nxt.addr = st_r.stack_top_pointer + 8'h01;
              st_nxt.stack_top_pointer = st_r.stack_top_pointer + 8'h01;
              st_nxt.write = 1'b1;
              st_nxt.tgt = CMSD_T_RAM;
            end
            CMSD_K_POP: begin
              st_nxt.addr = st_r.stack_top_pointer;
              st_nxt.stack_top_pointer = st_r.stack_top_pointer - 8'h01;
              st_nxt.write = 1'b0;
              st_nxt.tgt = CMSD_T_RAM;
            end
            CMSD_K_CODE, CMSD_K_XMOVE: begin
              st_nxt.pmem_addr = req_addr_i;
              st_nxt.xd_addr = req_addr_i;
              st_nxt.pmem_wdata = req_wdata_i;
              st_nxt.xd_wdata = req_wdata_i;
              if (req_kind_i == CMSD_K_XMOVE &&
                  !(req_write_i && st_r.program_store_control[CMSD_STORE_WREN_BIT])) begin
                st_nxt.tgt = CMSD_T_XDATA;
                st_nxt.xd_rd = !req_write_i;
                st_nxt.xd_wr = req_write_i;
              end else if (req_addr_i > CMSD_CODE_USABLE_TOP) begin
                st_nxt.err = 1'b1;
              end else begin
                st_nxt.tgt = CMSD_T_PMEM;
                st_nxt.pmem_rd = (req_kind_i == CMSD_K_CODE) || !req_write_i;
                st_nxt.pmem_wr = (req_kind_i == CMSD_K_XMOVE) && req_write_i;
              end
            end
          endcase
          // first step on the data side
          if (st_nxt.tgt == CMSD_T_RAM) begin
            ram_en = 1'b1;
            ram_we = st_nxt.write && !st_nxt.isbit && st_nxt.st == CMSD_S_READ;
            ram_addr = st_nxt.addr;
            ram_wdata = req_wdata_i;
          end else if (st_nxt.tgt == CMSD_T_SFRX) begin
            st_nxt.sfr_addr = st_nxt.addr;
            st_nxt.sfr_wdata = req_wdata_i;
            st_nxt.sfr_rd = !req_write_i || st_nxt.isbit;
            st_nxt.sfr_wr = req_write_i && !st_nxt.isbit;
          end else if (st_nxt.tgt == CMSD_T_SFRI && req_write_i && !st_nxt.isbit) begin
            case (st_nxt.addr)
              CMSD_STACK_TOP_POINTER_ADDR: st_nxt.stack_top_pointer = req_wdata_i;
              CMSD_PROGRAM_STORE_CONTROL_ADDR: st_nxt.program_store_control = req_wdata_i;
              CMSD_PROCESSOR_STATUS_WORD_ADDR: st_nxt.processor_status_word = req_wdata_i;
              default: ;
            endcase
          end
          st_nxt.ready = 1'b0;
        end
      end
      CMSD_S_PTR: begin
        st_nxt.addr = ram_q;
        ram_en = 1'b1;
        ram_we = st_r.write;
        ram_addr = ram_q;
        ram_wdata = st_r.wdata;
        st_nxt.st = CMSD_S_READ;
      end
      CMSD_S_READ: begin
        unique case (st_r.tgt)
          CMSD_T_RAM: data = ram_q;
          CMSD_T_SFRI: data = local_sfr_rd(st_r.addr, st_r);
          CMSD_T_SFRX: data = sfr_rdata_i;
          CMSD_T_PMEM: data = pmem_rdata_i;
          CMSD_T_XDATA: data = xdata_rdata_i;
          default: data = 8'hFF;
        endcase
        newb = set_bit(data, st_r.bitpos, st_r.bitval);
        // bit write finishes as read-modify-write
        if (st_r.isbit && st_r.write) begin
          if (st_r.tgt == CMSD_T_RAM) begin
            ram_en = 1'b1;
            ram_we = 1'b1;
            ram_addr = st_r.addr;
            ram_wdata = newb;
          end else if (st_r.tgt == CMSD_T_SFRX) begin
            st_nxt.sfr_wr = 1'b1;
            st_nxt.sfr_wdata = newb;
          end else if (st_r.addr == CMSD_PROCESSOR_STATUS_WORD_ADDR) begin
            st_nxt.processor_status_word = newb;
          end
        end
        st_nxt.rdata = data;
        st_nxt.rbit = data[st_r.bitpos];
        st_nxt.done = 1'b1;
        st_nxt.ready = 1'b1;
        st_nxt.st = CMSD_S_IDLE;
      end
      default: begin
        st_nxt.st = CMSD_S_IDLE;
        st_nxt.ready = 1'b1;
      end
    endcase
  end

  // single state register, frozen while ce_i is low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= CMSD_RST;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign ready_o = st_r.ready;
  assign done_o = st_r.done;
  assign rdata_o = st_r.rdata;
  assign rbit_o = st_r.rbit;
  assign err_o = st_r.err;
  assign stack_top_pointer_o = st_r.stack_top_pointer;
  assign program_store_control_o = st_r.program_store_control;
  assign processor_status_word_o = st_r.processor_status_word;
  assign sfr_rd_o = st_r.sfr_rd;
  assign sfr_wr_o = st_r.sfr_wr;
  assign sfr_addr_o = st_r.sfr_addr;
  assign sfr_wdata_o = st_r.sfr_wdata;
  assign pmem_rd_o = st_r.pmem_rd;
  assign pmem_wr_o = st_r.pmem_wr;
  assign pmem_addr_o = st_r.pmem_addr;
  assign pmem_wdata_o = st_r.pmem_wdata;
  assign xdata_rd_o = st_r.xd_rd;
  assign xdata_wr_o = st_r.xd_wr;
  assign xdata_addr_o = st_r.xd_addr;
  assign xdata_wdata_o = st_r.xd_wdata;

endmodule

// *** dv/cmsd_decoder_properties.sv ***
// cmsd_decoder_checker: timing and steering checks on the decoder ports.
// assumes one clock domain and the decoder's answer timing: two cycles, three for an indirect access.
`timescale 1ns/1ps
module cmsd_decoder_checker
  import cmsd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // request side
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire cmsd_pkg::cmsd_kind_t req_kind_i,
  input wire logic [15:0] req_addr_i,
  input wire logic req_write_i,
  // answer side
  input wire logic ready_o,
  input wire logic done_o,
  input wire logic [7:0] rdata_o,
  input wire logic err_o,
  input wire logic [7:0] stack_top_pointer_o,
  input wire logic [7:0] program_store_control_o,
  // outward strobes
  input wire logic sfr_rd_o,
  input wire logic sfr_wr_o,
  input wire logic [7:0] sfr_addr_o,
  input wire logic pmem_rd_o,
  input wire logic pmem_wr_o,
  input wire logic [15:0] pmem_addr_o,
  input wire logic xdata_wr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // request taken and sfr kept outside
  logic take;
  logic ext_sfr;
  assign take = ce_i && req_valid_i && ready_o;
  assign ext_sfr = req_addr_i[7] && !(req_addr_i[7:0] inside {CMSD_STACK_TOP_POINTER_ADDR,
    CMSD_PROGRAM_STORE_CONTROL_ADDR, CMSD_PROCESSOR_STATUS_WORD_ADDR});
  // answer moments
  sequence s_ans2;
    ##2 done_o;
  endsequence
  sequence s_ans3;
    ##3 done_o;
  endsequence
  property p_ready_drop;
    take |=> !ready_o;
  endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready high after take");
  property p_ans2;
    take && req_kind_i != CMSD_K_INDIRECT |-> s_ans2;
  endproperty
  a_ans2: assert property (p_ans2)
    else $error("answer late or early");
  property p_ans3;
    take && req_kind_i == CMSD_K_INDIRECT |-> s_ans3;
  endproperty
  a_ans3: assert property (p_ans3)
    else $error("indirect answer late or early");
  property p_push;
    take && req_kind_i == CMSD_K_PUSH |=>
      stack_top_pointer_o == 8'($past(stack_top_pointer_o) + 8'h01);
  endproperty
  a_push: assert property (p_push)
    else $error("push pointer step wrong");
  property p_pop;
    take && req_kind_i == CMSD_K_POP |=>
      stack_top_pointer_o == 8'($past(stack_top_pointer_o) - 8'h01);
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop pointer step wrong");
  property p_sfr_direct;
    take && req_kind_i == CMSD_K_DIRECT && ext_sfr |=>
      (sfr_rd_o || sfr_wr_o) && sfr_addr_o == $past(req_addr_i[7:0]);
  endproperty
  a_sfr_direct: assert property (p_sfr_direct)
    else $error("direct upper access missed sfr");
  property p_ind_ram;
    take && req_kind_i == CMSD_K_INDIRECT |=> (!sfr_rd_o && !sfr_wr_o) [*3];
  endproperty
  a_ind_ram: assert property (p_ind_ram)
    else $error("indirect access reached sfr");
  property p_xmove;
    take && req_kind_i == CMSD_K_XMOVE && req_write_i && req_addr_i <= CMSD_CODE_USABLE_TOP
      |=> pmem_wr_o == program_store_control_o[0] && xdata_wr_o == !program_store_control_o[0]
      && (!pmem_wr_o || pmem_addr_o == $past(req_addr_i));
  endproperty
  a_xmove: assert property (p_xmove)
    else $error("store write steering wrong");
  property p_reserved;
    take && req_kind_i == CMSD_K_CODE && req_addr_i > CMSD_CODE_USABLE_TOP
      |=> (!pmem_rd_o && !pmem_wr_o) ##1 (done_o && err_o && rdata_o == 8'hff);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved program address reached store");
endmodule
bind cmsd_decoder cmsd_decoder_checker cmsd_decoder_checker_inst (.*);

// *** dv/cmsd_space_model.sv ***
// cmsd_space_model: outside space (sfr, program store or external data).
// assumes strobes from the decoder; answers combinationally in the strobe cycle.
`timescale 1ns/1ps
module cmsd_space_model #(
  parameter logic [7:0] PRESET = 8'h00
) (
  // clock
  input wire logic clk_i,
  // strobes from the decoder
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  // read data, valid in the strobe cycle only
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  logic [7:0] last;
  // preset contents so the bench knows them
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ PRESET;
    end
    last = 8'h00;
  end
  // outside the strobe the bus shows the inverse of the last value
  assign rdata_o = rd_i ? mem[addr_i] : ~last;
  // store writes, remember last read value
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (rd_i) begin
      last <= mem[addr_i];
    end
  end
endmodule

// *** dv/cmsd_decoder_tb_top.sv ***
// cmsd_decoder_tb_top: self-checking bench for the memory space decoder.
// assumes the outside spaces are the preset space models.
`timescale 1ns/1ps
module cmsd_decoder_tb_top;
  import cmsd_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic req_valid_i = 1'b0;
  cmsd_kind_t req_kind_i = CMSD_K_DIRECT;
  logic [15:0] req_addr_i = 16'h0000;
  logic req_write_i = 1'b0;
  logic [7:0] req_wdata_i = 8'h00;
  logic req_bit_i = 1'b0;
  logic ready_o, done_o, rbit_o, err_o, sfr_rd_o, sfr_wr_o, pmem_rd_o, pmem_wr_o;
  logic xdata_rd_o, xdata_wr_o;
  logic [7:0] rdata_o, stack_top_pointer_o, program_store_control_o, processor_status_word_o;
  logic [7:0] sfr_addr_o, sfr_wdata_o, sfr_rdata_i, pmem_wdata_o, pmem_rdata_i;
  logic [7:0] xdata_wdata_o, xdata_rdata_i, rd;
  logic [15:0] pmem_addr_o, xdata_addr_o;
  logic rb, er;
  int errors = 0;
  int comparisons = 0;
  // device and the three outside spaces
  cmsd_decoder cmsd_decoder_inst (.*);
  cmsd_space_model #(.PRESET(8'hff)) sfr_inst (.clk_i(clk_i), .rd_i(sfr_rd_o),
    .wr_i(sfr_wr_o), .addr_i(sfr_addr_o), .wdata_i(sfr_wdata_o), .rdata_o(sfr_rdata_i));
  cmsd_space_model #(.PRESET(8'hc3)) pmem_inst (.clk_i(clk_i), .rd_i(pmem_rd_o),
    .wr_i(pmem_wr_o), .addr_i(pmem_addr_o[7:0]), .wdata_i(pmem_wdata_o),
    .rdata_o(pmem_rdata_i));
  cmsd_space_model #(.PRESET(8'h3c)) xdata_inst (.clk_i(clk_i), .rd_i(xdata_rd_o),
    .wr_i(xdata_wr_o), .addr_i(xdata_addr_o[7:0]), .wdata_i(xdata_wdata_o),
    .rdata_o(xdata_rdata_i));
  // clock
  always #4 clk_i = ~clk_i;
  // compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request: hold until taken, then wait for the answer
  task acc(input cmsd_kind_t k, input logic [15:0] a, input logic w, input logic [7:0] d,
    input logic b);
    int n;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_kind_i <= k;
    req_addr_i <= a;
    req_write_i <= w;
    req_wdata_i <= d;
    req_bit_i <= b;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ready_o !== 1'b1 && n < 8);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 8);
    chk(done_o, 1'b1);
    rd = rdata_o;
    rb = rbit_o;
    er = err_o;
  endtask
  task rchk(input cmsd_kind_t k, input logic [15:0] a, input logic [7:0] exp);
    acc(k, a, 1'b0, 8'h00, 1'b0);
    chk(rd, exp);
  endtask
  task t_reset;
    chk(stack_top_pointer_o, 8'h07);
    chk(program_store_control_o, 8'h00);
    chk(processor_status_word_o, 8'h00);
    chk(ready_o, 1'b1);
  endtask
  task t_stack;
    acc(CMSD_K_PUSH, 16'h0000, 1'b0, 8'h3c, 1'b0);
    chk(stack_top_pointer_o, 8'h08);
    rchk(CMSD_K_DIRECT, 16'h0008, 8'h3c);
    acc(CMSD_K_DIRECT, 16'h0081, 1'b1, 8'hfe, 1'b0);
    rchk(CMSD_K_DIRECT, 16'h0081, 8'hfe);
    acc(CMSD_K_PUSH, 16'h0000, 1'b0, 8'h11, 1'b0);
    acc(CMSD_K_PUSH, 16'h0000, 1'b0, 8'h22, 1'b0);
    chk(stack_top_pointer_o, 8'h00);
    acc(CMSD_K_POP, 16'h0000, 1'b0, 8'h00, 1'b0);
    chk(rd, 8'h22);
    acc(CMSD_K_POP, 16'h0000, 1'b0, 8'h00, 1'b0);
    chk(rd, 8'h11);
    chk(stack_top_pointer_o, 8'hfe);
  endtask
  task t_banks;
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      b = 8'(i);
      acc(CMSD_K_DIRECT, 16'h00d0, 1'b1, b << 3, 1'b0);
      chk(processor_status_word_o, b << 3);
      acc(CMSD_K_REGN, 16'h0000, 1'b1, 8'h40 + b, 1'b0);
      acc(CMSD_K_REGN, 16'h0001, 1'b1, 8'hc0 + b, 1'b0);
      rchk(CMSD_K_DIRECT, {8'h00, b << 3}, 8'h40 + b);
      acc(CMSD_K_INDIRECT, 16'h0000, 1'b1, 8'h50 + b, 1'b0);
      rchk(CMSD_K_DIRECT, {8'h00, 8'h40 + b}, 8'h50 + b);
      acc(CMSD_K_INDIRECT, 16'h0001, 1'b1, 8'ha0 + b, 1'b0);
      rchk(CMSD_K_INDIRECT, 16'h0001, 8'ha0 + b);
      rchk(CMSD_K_DIRECT, {8'h00, 8'hc0 + b}, ~(8'hc0 + b));
    end
    acc(CMSD_K_DIRECT, 16'h00d0, 1'b1, 8'h00, 1'b0);
  endtask
  task t_bits;
    acc(CMSD_K_DIRECT, 16'h0022, 1'b1, 8'h00, 1'b0);
    acc(CMSD_K_DIRECT, 16'h002f, 1'b1, 8'h00, 1'b0);
    acc(CMSD_K_BIT, 16'h0013, 1'b1, 8'h00, 1'b1);
    rchk(CMSD_K_DIRECT, 16'h0022, 8'h08);
    acc(CMSD_K_BIT, 16'h0013, 1'b0, 8'h00, 1'b0);
    chk(rb, 1'b1);
    acc(CMSD_K_BIT, 16'h007f, 1'b1, 8'h00, 1'b1);
    rchk(CMSD_K_DIRECT, 16'h002f, 8'h80);
    acc(CMSD_K_BIT, 16'h0093, 1'b1, 8'h00, 1'b0);
    rchk(CMSD_K_DIRECT, 16'h0090, 8'h67);
    acc(CMSD_K_BIT, 16'h00d4, 1'b1, 8'h00, 1'b1);
    chk(processor_status_word_o, 8'h10);
    acc(CMSD_K_REGN, 16'h0002, 1'b1, 8'h5a, 1'b0);
    rchk(CMSD_K_DIRECT, 16'h0012, 8'h5a);
    acc(CMSD_K_BIT, 16'h00d4, 1'b1, 8'h00, 1'b0);
    chk(processor_status_word_o, 8'h00);
  endtask
  task t_prog;
    rchk(CMSD_K_CODE, 16'h0000, 8'hc3);
    rchk(CMSD_K_CODE, 16'h3dff, 8'h3c);
    chk(er, 1'b0);
    rchk(CMSD_K_CODE, 16'h3e00, 8'hff);
    chk(er, 1'b1);
    acc(CMSD_K_XMOVE, 16'h0105, 1'b1, 8'h77, 1'b0);
    acc(CMSD_K_DIRECT, 16'h008f, 1'b1, 8'h01, 1'b0);
    acc(CMSD_K_XMOVE, 16'h0105, 1'b1, 8'h99, 1'b0);
    rchk(CMSD_K_CODE, 16'h0105, 8'h99);
    acc(CMSD_K_DIRECT, 16'h008f, 1'b1, 8'h00, 1'b0);
    rchk(CMSD_K_XMOVE, 16'h0105, 8'h77);
    acc(CMSD_K_DIRECT, 16'h0030, 1'b1, 8'h12, 1'b0);
    rchk(CMSD_K_CODE, 16'h0030, 8'hf3);
    rchk(CMSD_K_DIRECT, 16'h0030, 8'h12);
  endtask
  // verdict and end of run
  task tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_stack();
    t_banks();
    t_bits();
    t_prog();
    tally_and_finish();
  end
endmodule
